/* File: inc/sic_pkg.sv */
// constants, opcodes and checksum for the maintenance command interpreter
// assumes one 100 MHz clock shared by both ends of the byte link
// Function
// R1: serial readout 0x3682 gives 9 bytes within 1 ms
// R2: serial is word0<<32 | word1<<16 | word2
// R3: each response word followed by its checksum
// R4: self-test 0x3639 returns 3 bytes, wait 5500 ms
// R5: self-test word zero means no malfunction
// R6: defaults restore 0x3632 clears settings and histories
// R7: settings reload 0x3646, no answer, 20 ms
// R8: stop measuring before asking settings reload
// R9: single shot: send, wait full time, then read
// R10: full single shot 0x219d, no answer, 1350 ms
// R11: climate shot 0x2196, 50 ms, gas reads 0
// R12: baseline correction on by default for shots
// R13: longer shot spacing makes corrections less frequent
// R14: single shots only on high accuracy variant
// R15: checksum crc8 poly 0x31 init 0xff, no reflect
// R16: command words carry no checksum byte
// R17: command sent msb first in one write
package sic_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned MS_HZ = 1000;
  localparam int unsigned CYC_PER_MS_DEF = CLK_HZ / MS_HZ;

  localparam logic [15:0] CMD_SERIAL = 16'h3682;
  localparam logic [15:0] CMD_SELF_TEST = 16'h3639;
  localparam logic [15:0] CMD_RESTORE = 16'h3632;
  localparam logic [15:0] CMD_RELOAD = 16'h3646;
  localparam logic [15:0] CMD_SHOT_FULL = 16'h219d;
  localparam logic [15:0] CMD_SHOT_CLIMATE = 16'h2196;

  // longest execution times in ms
  localparam int unsigned DUR_SERIAL_MS = 1;
  localparam int unsigned DUR_SELF_TEST_MS = 5500;
  localparam int unsigned DUR_RESTORE_MS = 1200;
  localparam int unsigned DUR_RELOAD_MS = 20;
  localparam int unsigned DUR_SHOT_FULL_MS = 1350;
  localparam int unsigned DUR_SHOT_CLIMATE_MS = 50;

  localparam logic [3:0] LEN_SERIAL = 4'h9;
  localparam logic [3:0] LEN_SELF_TEST = 4'h3;
  localparam int unsigned RESP_MAX = 9;
  localparam int unsigned WORDS_MAX = 3;

  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'hff;
  localparam logic [15:0] TEST_FAULT_DEF = 16'h0001;
  localparam int unsigned ABC_SHOTS_DEF = 1;

  typedef enum logic [2:0] {
    OP_NONE, OP_SERIAL, OP_SELF_TEST, OP_RESTORE, OP_RELOAD,
    OP_SHOT_FULL, OP_SHOT_CLIMATE
  } sic_op_t;

  function automatic logic [7:0] sic_crc8(input logic [15:0] word);
    logic [7:0] crc;
    crc = CRC_INIT;
    for (int b = 15; b >= 0; b--) begin
      if (crc[7] ^ word[b]) begin
        crc = {crc[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        crc = {crc[6:0], 1'b0};
      end
    end
    return crc;
  endfunction

  function automatic logic [15:0] sic_cmd_word(input sic_op_t op);
    case (op)
      OP_SERIAL: return CMD_SERIAL;
      OP_SELF_TEST: return CMD_SELF_TEST;
      OP_RESTORE: return CMD_RESTORE;
      OP_RELOAD: return CMD_RELOAD;
      OP_SHOT_FULL: return CMD_SHOT_FULL;
      OP_SHOT_CLIMATE: return CMD_SHOT_CLIMATE;
      default: return 16'h0000;
    endcase
  endfunction

  function automatic int unsigned sic_dur_ms(input sic_op_t op);
    case (op)
      OP_SERIAL: return DUR_SERIAL_MS;
      OP_SELF_TEST: return DUR_SELF_TEST_MS;
      OP_RESTORE: return DUR_RESTORE_MS;
      OP_RELOAD: return DUR_RELOAD_MS;
      OP_SHOT_FULL: return DUR_SHOT_FULL_MS;
      OP_SHOT_CLIMATE: return DUR_SHOT_CLIMATE_MS;
      default: return DUR_SERIAL_MS;
    endcase
  endfunction
endpackage

/* File: inc/sic_link_if.sv */
// byte link standing in for the two-wire bus transactions
// assumes both ends on one clock; host drives writes and read requests
interface sic_link_if;
  logic wr_vld;
  logic wr_start;
  logic [7:0] wr_byte;
  logic rd_req;
  logic rd_start;
  logic rd_ack;
  logic rd_nack;
  logic [7:0] rd_data;

  modport dev (
    input wr_vld, wr_start, wr_byte, rd_req, rd_start,
    output rd_ack, rd_nack, rd_data
  );
  modport host (
    output wr_vld, wr_start, wr_byte, rd_req, rd_start,
    input rd_ack, rd_nack, rd_data
  );
endinterface

/* File: verilog/sic_device.sv */
// device end: decodes maintenance and single shot commands, times them
// assumes host keeps to the documented waits and byte order
module sic_device
  import sic_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = CYC_PER_MS_DEF,
  parameter bit HIGH_ACCURACY = 1'b1,
  parameter int unsigned ABC_SHOTS = ABC_SHOTS_DEF
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // link
  sic_link_if.dev LINK,
  // identity and self-test sources
  input wire logic [47:0] SERIAL_NUMBER,
  input wire logic SELF_TEST_FAULT,
  input wire logic [15:0] SELF_TEST_CODE,
  // measurement engine status and baseline control
  input wire logic MEAS_ACTIVE,
  input wire logic ABC_SET,
  input wire logic ABC_SET_VALUE,
  // action strobes
  output logic NVM_RESTORE,
  output logic BASELINE_ERASE,
  output logic SETTINGS_RELOAD,
  output logic SHOT_FULL_START,
  output logic SHOT_CLIMATE_START,
  output logic ABC_RUN,
  // levels
  output logic ABC_ENABLE,
  output logic GAS_ZERO,
  output logic CMD_BUSY
);
  initial begin
    if (CYC_PER_MS < 1 || CYC_PER_MS > 400_000) begin
      $error("CYC_PER_MS out of range");
    end
    if (ABC_SHOTS < 1 || ABC_SHOTS > 65535) begin
      $error("ABC_SHOTS out of range");
    end
  end

  typedef enum logic [0:0] {ST_IDLE, ST_BUSY} sic_dev_state_t;

  sic_dev_state_t state, next_state;
  sic_op_t op, next_op;
  logic [31:0] timer, next_timer;
  logic have_hi, next_have_hi;
  logic [7:0] cmd_hi, next_cmd_hi;
  logic [7:0] resp [RESP_MAX];
  logic [7:0] next_resp [RESP_MAX];
  logic [3:0] resp_len, next_resp_len;
  logic [3:0] rd_idx, next_rd_idx;
  logic [15:0] shots, next_shots;
  logic rd_ack, next_rd_ack;
  logic rd_nack, next_rd_nack;
  logic [7:0] rd_data, next_rd_data;
  logic next_nvm_restore, next_baseline_erase, next_settings_reload;
  logic next_shot_full, next_shot_climate, next_abc_run;
  logic next_abc_enable, next_gas_zero;

  function automatic sic_op_t decode(input logic [15:0] w);
    case (w)
      CMD_SERIAL: return OP_SERIAL;
      CMD_SELF_TEST: return OP_SELF_TEST;
      CMD_RESTORE: return OP_RESTORE;
      CMD_RELOAD: return OP_RELOAD;
      CMD_SHOT_FULL: return HIGH_ACCURACY ? OP_SHOT_FULL : OP_NONE; // R14
      CMD_SHOT_CLIMATE: return HIGH_ACCURACY ? OP_SHOT_CLIMATE : OP_NONE;
      default: return OP_NONE;
    endcase
  endfunction

  always_comb begin
    logic [15:0] cmd;
    logic [15:0] test_word;
    sic_op_t dec;
    cmd = {cmd_hi, LINK.wr_byte};
    dec = OP_NONE;
    test_word = 16'h0000;
    next_state = state;
    next_op = op;
    next_timer = timer;
    next_have_hi = have_hi;
    next_cmd_hi = cmd_hi;
    next_resp = resp;
    next_resp_len = resp_len;
    next_rd_idx = rd_idx;
    next_shots = shots;
    next_rd_ack = 1'b0;
    next_rd_nack = 1'b0;
    next_rd_data = rd_data;
    next_nvm_restore = 1'b0;
    next_baseline_erase = 1'b0;
    next_settings_reload = 1'b0;
    next_shot_full = 1'b0;
    next_shot_climate = 1'b0;
    next_abc_run = 1'b0;
    next_abc_enable = ABC_SET ? ABC_SET_VALUE : ABC_ENABLE;
    next_gas_zero = GAS_ZERO;
    case (state)
      ST_IDLE: begin
        // writes are ignored while busy, as the device would not answer
        if (LINK.wr_vld) begin
          if (LINK.wr_start) begin
            next_cmd_hi = LINK.wr_byte; // R17
            next_have_hi = 1'b1;
            next_resp_len = 4'h0;
          end else if (have_hi) begin
            next_have_hi = 1'b0;
            // second byte ends the command; no checksum expected
            dec = decode(cmd); // R16
            if (dec == OP_RELOAD && MEAS_ACTIVE) begin
              dec = OP_NONE; // R8
            end
            if (dec != OP_NONE) begin
              next_op = dec;
              next_state = ST_BUSY;
              next_timer = 32'(sic_dur_ms(dec) * CYC_PER_MS - 1);
            end
            case (dec)
              OP_RESTORE: begin
                next_nvm_restore = 1'b1; // R6
                next_baseline_erase = 1'b1; // R6
                next_abc_enable = 1'b1; // R12
                next_shots = 16'h0000;
              end
              OP_RELOAD: next_settings_reload = 1'b1; // R7
              OP_SHOT_FULL: next_shot_full = 1'b1; // R10
              OP_SHOT_CLIMATE: next_shot_climate = 1'b1; // R11
              default: begin
              end
            endcase
          end
        end
      end
      ST_BUSY: begin
        if (timer == 32'h0) begin
          next_state = ST_IDLE;
          next_rd_idx = 4'h0;
          case (op)
            OP_SERIAL: begin
              // words big-endian, each followed by its checksum
              for (int w = 0; w < WORDS_MAX; w++) begin
                next_resp[3*w] = SERIAL_NUMBER[47-16*w -: 8]; // R2
                next_resp[3*w+1] = SERIAL_NUMBER[39-16*w -: 8];
                next_resp[3*w+2] = sic_crc8(SERIAL_NUMBER[47-16*w -: 16]); // R3
              end
              next_resp_len = LEN_SERIAL; // R1
            end
            OP_SELF_TEST: begin
              // a fault flagged with a zero code must still read nonzero
              if (SELF_TEST_FAULT) begin
                test_word = (SELF_TEST_CODE == 16'h0000) ?
                  TEST_FAULT_DEF : SELF_TEST_CODE; // R5
              end
              next_resp[0] = test_word[15:8];
              next_resp[1] = test_word[7:0];
              next_resp[2] = sic_crc8(test_word); // R15
              next_resp_len = LEN_SELF_TEST; // R4
            end
            OP_SHOT_FULL, OP_SHOT_CLIMATE: begin
              next_gas_zero = (op == OP_SHOT_CLIMATE); // R11
              // correction steps counted per shot, so sparse shots slow it
              if (ABC_ENABLE) begin
                if (shots >= 16'(ABC_SHOTS - 1)) begin
                  next_shots = 16'h0000;
                  next_abc_run = 1'b1; // R13
                end else begin
                  next_shots = shots + 16'h0001;
                end
              end
            end
            default: begin
            end
          endcase
        end else begin
          next_timer = timer - 32'h1;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (LINK.rd_req) begin
      if (state == ST_BUSY) begin
        next_rd_nack = 1'b1;
      end else if (LINK.rd_start) begin
        if (resp_len == 4'h0) begin
          next_rd_nack = 1'b1;
        end else begin
          next_rd_ack = 1'b1;
          next_rd_data = resp[0];
          next_rd_idx = 4'h1;
        end
      end else if (rd_idx < resp_len) begin
        next_rd_ack = 1'b1;
        next_rd_data = resp[rd_idx];
        next_rd_idx = rd_idx + 4'h1;
      end else begin
        next_rd_nack = 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      state <= ST_IDLE;
      op <= OP_NONE;
      timer <= 32'h0;
      have_hi <= 1'b0;
      cmd_hi <= 8'h00;
      for (int i = 0; i < RESP_MAX; i++) begin
        resp[i] <= 8'h00;
      end
      resp_len <= 4'h0;
      rd_idx <= 4'h0;
      shots <= 16'h0000;
      rd_ack <= 1'b0;
      rd_nack <= 1'b0;
      rd_data <= 8'h00;
      NVM_RESTORE <= 1'b0;
      BASELINE_ERASE <= 1'b0;
      SETTINGS_RELOAD <= 1'b0;
      SHOT_FULL_START <= 1'b0;
      SHOT_CLIMATE_START <= 1'b0;
      ABC_RUN <= 1'b0;
      ABC_ENABLE <= 1'b1; // R12
      GAS_ZERO <= 1'b0;
      CMD_BUSY <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      timer <= next_timer;
      have_hi <= next_have_hi;
      cmd_hi <= next_cmd_hi;
      resp <= next_resp;
      resp_len <= next_resp_len;
      rd_idx <= next_rd_idx;
      shots <= next_shots;
      rd_ack <= next_rd_ack;
      rd_nack <= next_rd_nack;
      rd_data <= next_rd_data;
      NVM_RESTORE <= next_nvm_restore;
      BASELINE_ERASE <= next_baseline_erase;
      SETTINGS_RELOAD <= next_settings_reload;
      SHOT_FULL_START <= next_shot_full;
      SHOT_CLIMATE_START <= next_shot_climate;
      ABC_RUN <= next_abc_run;
      ABC_ENABLE <= next_abc_enable;
      GAS_ZERO <= next_gas_zero;
      CMD_BUSY <= (next_state == ST_BUSY);
    end
  end

  assign LINK.rd_ack = rd_ack;
  assign LINK.rd_nack = rd_nack;
  assign LINK.rd_data = rd_data;
endmodule

/* File: verilog/sic_host.sv */
// host end: sends one command, waits its full time, reads and checks the serial and self-test answers
// assumes the device end on the same clock and byte link
module sic_host
  import sic_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = CYC_PER_MS_DEF
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // link
  sic_link_if.host LINK,
  // request
  input wire logic REQ,
  input wire sic_op_t REQ_OP,
  input wire logic MEAS_ACTIVE,
  // answer
  output logic BUSY,
  output logic DONE,
  output logic REFUSED,
  output logic CRC_ERR,
  output logic NO_DATA,
  output logic [47:0] SERIAL,
  output logic [15:0] TEST_WORD
);
  initial begin
    if (CYC_PER_MS < 1 || CYC_PER_MS > 400_000) begin
      $error("CYC_PER_MS out of range");
    end
  end

  typedef enum logic [2:0] {
    H_IDLE, H_SEND_HI, H_SEND_LO, H_WAIT, H_READ, H_READ_WAIT, H_FIN
  } sic_host_state_t;

  sic_host_state_t state, next_state;
  sic_op_t op, next_op;
  logic [31:0] timer, next_timer;
  logic [7:0] rx [RESP_MAX];
  logic [7:0] next_rx [RESP_MAX];
  logic [3:0] idx, next_idx;
  logic wr_vld, next_wr_vld, wr_start, next_wr_start;
  logic [7:0] wr_byte, next_wr_byte;
  logic rd_req, next_rd_req, rd_start, next_rd_start;
  logic next_done, next_refused, next_crc_err, next_no_data;
  logic [47:0] next_serial;
  logic [15:0] next_test_word;

  always_comb begin
    logic [15:0] cmd;
    logic [3:0] need;
    logic bad;
    cmd = sic_cmd_word(op);
    need = (op == OP_SERIAL) ? LEN_SERIAL : LEN_SELF_TEST;
    bad = 1'b0;
    next_state = state;
    next_op = op;
    next_timer = timer;
    next_rx = rx;
    next_idx = idx;
    next_wr_vld = 1'b0;
    next_wr_start = 1'b0;
    next_wr_byte = wr_byte;
    next_rd_req = 1'b0;
    next_rd_start = 1'b0;
    next_done = 1'b0;
    next_refused = REFUSED;
    next_crc_err = CRC_ERR;
    next_no_data = NO_DATA;
    next_serial = SERIAL;
    next_test_word = TEST_WORD;
    case (state)
      H_IDLE: begin
        if (REQ) begin
          next_op = REQ_OP;
          next_refused = 1'b0;
          next_crc_err = 1'b0;
          next_no_data = 1'b0;
          if (REQ_OP == OP_NONE || (REQ_OP == OP_RELOAD && MEAS_ACTIVE)) begin
            next_refused = 1'b1; // R8
            next_done = 1'b1;
          end else begin
            next_state = H_SEND_HI;
          end
        end
      end
      H_SEND_HI: begin
        next_wr_vld = 1'b1;
        next_wr_start = 1'b1;
        next_wr_byte = cmd[15:8]; // R17
        next_state = H_SEND_LO;
      end
      H_SEND_LO: begin
        next_wr_vld = 1'b1;
        next_wr_byte = cmd[7:0]; // R16
        next_timer = 32'(sic_dur_ms(op) * CYC_PER_MS);
        next_state = H_WAIT;
      end
      H_WAIT: begin
        // full longest time, counted from the cycle after the last byte
        if (timer == 32'h0) begin
          next_idx = 4'h0;
          if (op == OP_SERIAL || op == OP_SELF_TEST) begin
            next_state = H_READ; // R4
          end else begin
            next_state = H_FIN; // R9
          end
        end else begin
          next_timer = timer - 32'h1;
        end
      end
      H_READ: begin
        next_rd_req = 1'b1;
        next_rd_start = (idx == 4'h0);
        next_state = H_READ_WAIT;
      end
      H_READ_WAIT: begin
        if (LINK.rd_ack) begin
          next_rx[idx] = LINK.rd_data;
          next_idx = idx + 4'h1;
          next_state = (idx + 4'h1 == need) ? H_FIN : H_READ;
        end else if (LINK.rd_nack) begin
          next_no_data = 1'b1;
          next_state = H_FIN;
        end
      end
      H_FIN: begin
        next_done = 1'b1;
        next_state = H_IDLE;
        if (!NO_DATA && op == OP_SERIAL) begin
          for (int w = 0; w < WORDS_MAX; w++) begin
            if (sic_crc8({rx[3*w], rx[3*w+1]}) != rx[3*w+2]) begin
              bad = 1'b1; // R15
            end
          end
          next_serial = {rx[0], rx[1], rx[3], rx[4], rx[6], rx[7]}; // R2
          next_crc_err = bad;
        end else if (!NO_DATA && op == OP_SELF_TEST) begin
          next_test_word = {rx[0], rx[1]};
          next_crc_err = (sic_crc8({rx[0], rx[1]}) != rx[2]); // R15
        end
      end
      default: next_state = H_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      state <= H_IDLE;
      op <= OP_NONE;
      timer <= 32'h0;
      for (int i = 0; i < RESP_MAX; i++) begin
        rx[i] <= 8'h00;
      end
      idx <= 4'h0;
      wr_vld <= 1'b0;
      wr_start <= 1'b0;
      wr_byte <= 8'h00;
      rd_req <= 1'b0;
      rd_start <= 1'b0;
      BUSY <= 1'b0;
      DONE <= 1'b0;
      REFUSED <= 1'b0;
      CRC_ERR <= 1'b0;
      NO_DATA <= 1'b0;
      SERIAL <= 48'h0;
      TEST_WORD <= 16'h0000;
    end else begin
      state <= next_state;
      op <= next_op;
      timer <= next_timer;
      rx <= next_rx;
      idx <= next_idx;
      wr_vld <= next_wr_vld;
      wr_start <= next_wr_start;
      wr_byte <= next_wr_byte;
      rd_req <= next_rd_req;
      rd_start <= next_rd_start;
      BUSY <= (next_state != H_IDLE);
      DONE <= next_done;
      REFUSED <= next_refused;
      CRC_ERR <= next_crc_err;
      NO_DATA <= next_no_data;
      SERIAL <= next_serial;
      TEST_WORD <= next_test_word;
    end
  end

  assign LINK.wr_vld = wr_vld;
  assign LINK.wr_start = wr_start;
  assign LINK.wr_byte = wr_byte;
  assign LINK.rd_req = rd_req;
  assign LINK.rd_start = rd_start;
endmodule

/* File: testbench/sic_link_checker.sv */
// checker: timing and framing on the byte link between the two ends
// assumes one clock; tb instantiates it beside the link interface
module sic_link_checker
  import sic_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = CYC_PER_MS_DEF
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // write side
  input wire logic wr_vld,
  input wire logic wr_start,
  input wire logic [7:0] wr_byte,
  // read side
  input wire logic rd_req,
  input wire logic rd_start,
  input wire logic rd_ack,
  input wire logic rd_nack,
  input wire logic [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_B);

  // saturating, so a long idle never wraps into a false short gap
  logic [31:0] gap;
  logic [31:0] next_gap;
  logic [3:0] idx;
  logic [3:0] next_idx;
  always_comb begin
    next_gap = (gap == 32'hffffffff) ? gap : gap + 32'h1;
    if (wr_vld && !wr_start) next_gap = 32'h0;
    next_idx = idx;
    if (rd_req && rd_start) next_idx = 4'h0;
    else if (rd_ack) next_idx = idx + 4'h1;
  end
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      gap <= 32'h0;
      idx <= 4'h0;
    end else begin
      gap <= next_gap;
      idx <= next_idx;
    end
  end

  a_answer_one_cycle: assert property (rd_req |=> rd_ack != rd_nack)
    else $error("read request not answered once");
  a_no_stray_answer: assert property (!rd_req |=> !rd_ack && !rd_nack)
    else $error("answer without read request");
  a_read_len_bound: assert property (rd_ack |-> idx < LEN_SERIAL)
    else $error("more than nine bytes acknowledged");
  a_data_holds: assert property (!rd_ack |-> $stable(rd_data))
    else $error("read data moved without acknowledge");
  a_cmd_first_byte: assert property (wr_vld && wr_start |->
    wr_byte inside {8'h36, 8'h21})
    else $error("command not opened by its high byte");
  a_maint_low_byte: assert property (wr_vld && wr_start && wr_byte == 8'h36
    |=> ##[0:3] wr_vld && !wr_start &&
    wr_byte inside {8'h82, 8'h39, 8'h32, 8'h46})
    else $error("maintenance low byte missing");
  a_shot_low_byte: assert property (wr_vld && wr_start && wr_byte == 8'h21
    |=> ##[0:3] wr_vld && !wr_start && wr_byte inside {8'h9d, 8'h96})
    else $error("shot low byte missing");
  a_no_cmd_crc: assert property (wr_vld && !wr_start |=>
    (!wr_vld || wr_start) [*3])
    else $error("extra byte after command word");
  a_wait_before_read: assert property (rd_req && rd_start |->
    gap >= CYC_PER_MS)
    else $error("read started before command time");
endmodule

/* File: testbench/tb.sv */
// testbench: host end against device end, plus a driven second device
// assumes 100 MHz clock and the millisecond count shortened to 5 cycles
module tb
  import sic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // short enough that two full self-tests fit the cycle budget
  localparam int unsigned CPM = 5;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  int miscompares = 0;
  int check_count = 0;
  logic req = 1'b0;
  sic_op_t op = OP_NONE;
  logic meas = 1'b0;
  logic meas2 = 1'b0;
  logic [47:0] sn = 48'h1234_5678_9abc;
  logic abc_set = 1'b0;
  logic abv = 1'b0;
  logic stf = 1'b0;
  logic [15:0] stc = 16'h0000;
  logic busy, done, refused, crc_err, no_data;
  logic [47:0] serial;
  logic [15:0] test_word;
  logic [5:0] stb;
  logic [5:0] stb2;
  logic abc_en, gas_zero, cmd_busy, abc_en2, gas_zero2, busy2;
  int cnt [6] = '{default: 0};
  int cnt2 [6] = '{default: 0};
  logic a;
  logic [7:0] b;
  logic [7:0] exp9 [9] = '{8'hbe, 8'hef, 8'h92, 8'h00, 8'h00, 8'h81,
    8'h80, 8'h00, 8'ha2};
  sic_link_if lk();
  sic_link_if lk2();

  always #5 clk = ~clk;
  // strobe tallies: a missed or doubled pulse shows in the count
  always @(posedge clk) begin
    for (int i = 0; i < 6; i++) begin
      cnt[i] += stb[i];
      cnt2[i] += stb2[i];
    end
  end

  sic_host #(.CYC_PER_MS(CPM)) sic_host_inst (.SYS_CLK(clk), .RST_B(rst_b),
    .LINK(lk.host), .REQ(req), .REQ_OP(op), .MEAS_ACTIVE(meas), .BUSY(busy),
    .DONE(done), .REFUSED(refused), .CRC_ERR(crc_err), .NO_DATA(no_data),
    .SERIAL(serial), .TEST_WORD(test_word));
  sic_device #(.CYC_PER_MS(CPM)) sic_device_inst (.SYS_CLK(clk),
    .RST_B(rst_b), .LINK(lk.dev), .SERIAL_NUMBER(sn), .SELF_TEST_FAULT(stf),
    .SELF_TEST_CODE(stc), .MEAS_ACTIVE(meas), .ABC_SET(abc_set),
    .ABC_SET_VALUE(abv), .NVM_RESTORE(stb[0]), .BASELINE_ERASE(stb[1]),
    .SETTINGS_RELOAD(stb[2]), .SHOT_FULL_START(stb[3]),
    .SHOT_CLIMATE_START(stb[4]), .ABC_RUN(stb[5]), .ABC_ENABLE(abc_en),
    .GAS_ZERO(gas_zero), .CMD_BUSY(cmd_busy));
  // base variant, so shots must be ignored here
  sic_device #(.CYC_PER_MS(CPM), .HIGH_ACCURACY(1'b0)) sic_device_inst2 (
    .SYS_CLK(clk), .RST_B(rst_b), .LINK(lk2.dev), .SERIAL_NUMBER(sn),
    .SELF_TEST_FAULT(1'b0), .SELF_TEST_CODE(16'h0000), .MEAS_ACTIVE(meas2),
    .ABC_SET(abc_set), .ABC_SET_VALUE(abv), .NVM_RESTORE(stb2[0]),
    .BASELINE_ERASE(stb2[1]), .SETTINGS_RELOAD(stb2[2]),
    .SHOT_FULL_START(stb2[3]), .SHOT_CLIMATE_START(stb2[4]),
    .ABC_RUN(stb2[5]), .ABC_ENABLE(abc_en2), .GAS_ZERO(gas_zero2),
    .CMD_BUSY(busy2));
  sic_link_checker #(.CYC_PER_MS(CPM)) sic_link_checker_inst (.SYS_CLK(clk),
    .RST_B(rst_b), .wr_vld(lk.wr_vld), .wr_start(lk.wr_start),
    .wr_byte(lk.wr_byte), .rd_req(lk.rd_req), .rd_start(lk.rd_start),
    .rd_ack(lk.rd_ack), .rd_nack(lk.rd_nack), .rd_data(lk.rd_data));

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  task automatic run(input sic_op_t o, input logic exp_ref);
    int i;
    int hi;
    hi = 0;
    // an edge between requests, so req never flips twice in one step
    tick(1);
    req = 1'b1;
    op = o;
    tick(1);
    req = 1'b0;
    chk(busy, !exp_ref);
    for (i = 0; i < 60000 && done !== 1'b1; i++) begin
      hi += cmd_busy;
      tick(1);
    end
    if (i == 60000) begin
      miscompares++;
      give_verdict();
    end
    chk(refused, exp_ref);
    chk(hi, exp_ref ? 0 : sic_dur_ms(o) * CPM);
  endtask
  // released byte line shows the inverse, not the last value
  task automatic wcmd(input logic [15:0] w);
    lk2.wr_vld = 1'b1;
    lk2.wr_start = 1'b1;
    lk2.wr_byte = w[15:8];
    tick(1);
    lk2.wr_start = 1'b0;
    lk2.wr_byte = w[7:0];
    tick(1);
    lk2.wr_vld = 1'b0;
    lk2.wr_byte = ~w[7:0];
  endtask
  task automatic rd(input logic st, output logic ack, output logic [7:0] d);
    // one-cycle request pulse; the answer stands the cycle after it
    lk2.rd_req = 1'b1;
    lk2.rd_start = st;
    tick(1);
    ack = lk2.rd_ack;
    d = lk2.rd_data;
    lk2.rd_req = 1'b0;
    lk2.rd_start = 1'b0;
    tick(1);
  endtask
  task automatic wbusy();
    int i;
    for (i = 0; i < 300 && busy2 !== 1'b0; i++) tick(1);
    if (i == 300) begin
      miscompares++;
      give_verdict();
    end
  endtask

  initial begin
    lk2.wr_vld = 1'b0;
    lk2.wr_start = 1'b0;
    lk2.wr_byte = 8'h00;
    lk2.rd_req = 1'b0;
    lk2.rd_start = 1'b0;
    tick(5);
    rst_b = 1'b1;
    chk(abc_en, 1'b1);
    run(OP_SERIAL, 1'b0);
    chk(serial, sn);
    chk(crc_err | no_data, 1'b0);
    tend("serial");
    run(OP_SELF_TEST, 1'b0);
    chk(test_word, 16'h0000);
    // flagged fault with a zero code must still read nonzero
    stf = 1'b1;
    run(OP_SELF_TEST, 1'b0);
    chk({crc_err, no_data, test_word}, {2'b00, TEST_FAULT_DEF});
    stf = 1'b0;
    tend("self test");
    meas = 1'b1;
    run(OP_RELOAD, 1'b1);
    chk(cnt[2], 0);
    meas = 1'b0;
    run(OP_RELOAD, 1'b0);
    chk(cnt[2], 1);
    tend("reload");
    abc_set = 1'b1;
    tick(1);
    abc_set = 1'b0;
    tick(1);
    chk({abc_en, abc_en2}, 2'b00);
    run(OP_RESTORE, 1'b0);
    chk({cnt[0][7:0], cnt[1][7:0], 7'h0, abc_en}, 17'h10101);
    tend("restore");
    run(OP_SHOT_FULL, 1'b0);
    chk({cnt[3][7:0], 7'h0, gas_zero}, 16'h0100);
    run(OP_SHOT_CLIMATE, 1'b0);
    chk({cnt[4][7:0], 7'h0, gas_zero}, 16'h0101);
    chk(cnt[5] != 0, 1'b1);
    run(OP_NONE, 1'b1);
    tend("shots");
    sn = 48'hbeef_0000_8000;
    wcmd(16'h3682);
    tick(1);
    rd(1'b1, a, b);
    chk(a, 1'b0);
    wbusy();
    for (int i = 0; i < 10; i++) begin
      rd(i == 0, a, b);
      chk(a, i < 9);
      if (i < 9) chk(b, exp9[i]);
    end
    tend("serial bytes");
    wcmd(16'h8236);
    tick(2);
    chk(busy2, 1'b0);
    rd(1'b1, a, b);
    chk(a, 1'b0);
    wcmd(16'h2196);
    tick(2);
    chk({busy2, gas_zero2, cnt2[4][7:0]}, 10'h000);
    meas2 = 1'b1;
    wcmd(16'h3646);
    tick(2);
    chk(cnt2[2], 0);
    meas2 = 1'b0;
    wcmd(16'h3646);
    tick(2);
    chk(cnt2[2], 1);
    wbusy();
    tend("driven device");
    give_verdict();
  end
endmodule
